// ---- fccu_defines.svh ----
// Purpose: Offsets, field positions, codes, reset values and preset constants of the CRC unit.
// Assumes: Included by bare name from the design modules and the bench.
// Notes: Polynomials are held bit-reversed because frames go out least significant bit first.
`ifndef FCCU_DEFINES_SVH
`define FCCU_DEFINES_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define FCCU_TX_SETUP_ADDR 8'h2c
`define FCCU_RX_SETUP_ADDR 8'h2d
`define FCCU_STATUS_ADDR 8'h3f
`define FCCU_SETUP_RESET 8'h00
`define FCCU_TX_SETUP_MASK 8'h7f

// ****************************************************************
// Field positions of both setup registers and of the status register
// ****************************************************************
`define FCCU_ENABLE_BIT 0
`define FCCU_COMPL_BIT 1
`define FCCU_POLY_LSB 2
`define FCCU_POLY_MSB 3
`define FCCU_INIT_LSB 4
`define FCCU_INIT_MSB 6
`define FCCU_STORE_BIT 7
`define FCCU_STAT_ERR_BIT 0
`define FCCU_STAT_BUSY_BIT 1

// ****************************************************************
// Polynomial select codes and reversed polynomials
// ****************************************************************
`define FCCU_POLY_CRC5 2'h0
`define FCCU_POLY_CRC8 2'h1
`define FCCU_POLY_CRC16 2'h2
`define FCCU_POLY_RSVD 2'h3
`define FCCU_REV_POLY_CRC16 16'h8408
`define FCCU_REV_POLY_CRC8 16'h00b8
`define FCCU_REV_POLY_CRC5 16'h0014
`define FCCU_MASK_CRC16 16'hffff
`define FCCU_MASK_CRC8 16'h00ff
`define FCCU_MASK_CRC5 16'h001f

// ****************************************************************
// Initial value codes and fixed initial values
// ****************************************************************
`define FCCU_INIT_ZERO 3'h0
`define FCCU_INIT_CODE1 3'h1
`define FCCU_INIT_CODE2 3'h2
`define FCCU_INIT_CODE3 3'h3
`define FCCU_INIT_USER 3'h6
`define FCCU_INIT_ONES 3'h7
`define FCCU_PRE1_CRC16 16'h6363
`define FCCU_PRE1_SHORT 16'h0012
`define FCCU_PRE2_CRC16 16'ha671
`define FCCU_PRE2_CRC8 16'h00bf
`define FCCU_PRE3_CRC16 16'hfffe
`define FCCU_PRE3_CRC8 16'h00fd
`define FCCU_PRE7_CRC16 16'hffff
`define FCCU_PRE7_CRC8 16'h00ff
`define FCCU_PRE7_CRC5 16'h001f

`endif

// ---- fccu_pkg.sv ----
// Purpose: Types shared by the CRC unit modules.
// Assumes: Constants come from the defines header.
// Notes: Only types live here.
package fccu_pkg;
  typedef logic [1:0] fccu_poly_t;
  typedef logic [2:0] fccu_init_t;
  typedef logic [15:0] fccu_word_t;
  typedef enum logic [1:0] {TX_IDLE, TX_PASS, TX_CRC_LO, TX_CRC_HI} fccu_tx_state_e;
endpackage

// ---- fccu_crc_if.sv ----
// Purpose: Carries one CRC engine's load, feed and result signals.
// Assumes: One engine per direction.
// Notes: The result is the engine's register, valid one cycle after a load or feed.
`timescale 1ns/1ns
interface fccu_crc_if;
  import fccu_pkg::*;
  logic init;
  fccu_word_t init_value;
  fccu_poly_t poly;
  logic feed;
  logic [7:0] data;
  fccu_word_t crc;
  modport engine (input init, input init_value, input poly, input feed, input data, output crc);
  modport user (output init, output init_value, output poly, output feed, output data, input crc);
endinterface

// ---- fccu_crc_engine.sv ----
// Purpose: Byte-wide CRC shift register for CRC5, CRC8 and CRC16, least significant bit first.
// Assumes: Load and feed are never requested in the same cycle; load wins if they are.
// Notes: Narrow CRCs sit in the low bits; upper bits stay zero.
`timescale 1ns/1ns
`include "fccu_defines.svh"
module fccu_crc_engine
(
  input wire logic clk_in,
  input wire logic rst_in,
  fccu_crc_if.engine crc_bus
);
  import fccu_pkg::*;

  fccu_word_t crc_reg;
  fccu_word_t crc_next;

  // ****************************************************************
  // Bitwise update over one byte
  // ****************************************************************
  function automatic fccu_word_t crc_byte(input fccu_word_t crc, input logic [7:0] data,
                                          input fccu_poly_t poly);
    fccu_word_t c;
    fccu_word_t p;
    logic fb;
    c = crc;
    case (poly)
      `FCCU_POLY_CRC5: p = `FCCU_REV_POLY_CRC5;
      `FCCU_POLY_CRC8: p = `FCCU_REV_POLY_CRC8;
      default: p = `FCCU_REV_POLY_CRC16;
    endcase
    for (int i = 0; i < 8; i++)
    begin
      fb = c[0] ^ data[i];
      c = (c >> 1) ^ (fb ? p : 16'h0000);
    end
    return c;
  endfunction

  // Load the initial value at frame start, otherwise fold in each fed byte.
  always_comb
  begin
    crc_next = crc_reg;
    if (crc_bus.init)
      crc_next = crc_bus.init_value; // [RQ13]
    else if (crc_bus.feed)
      crc_next = crc_byte(crc_reg, crc_bus.data, crc_bus.poly); // [RQ1]
  end

  // Register stage.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      crc_reg <= 16'h0000;
    else
      crc_reg <= crc_next;
  end

  assign crc_bus.crc = crc_reg;
endmodule

// ---- fccu_top.sv ----
// Purpose: CRC append on transmit and CRC check on receive, set up by two 8-bit registers.
// Assumes: Framing logic gives start and end pulses in cycles with no data byte.
// Notes: The reserved polynomial code disables both appending and checking.
`timescale 1ns/1ns
`include "fccu_defines.svh"

// Function
// RQ1 - The two-bit polynomial field selects CRC5, CRC8 or CRC16, with code three reserved.
// RQ2 - With transmit append enabled the CRC of the outgoing frame follows its data.
// RQ3 - With transmit complement set the appended CRC is bitwise inverted.
// RQ4 - The transmit initial value code picks zeros, fixed constants or all ones per CRC type.
// RQ5 - The receive initial value code uses the same table, codes four and five undefined.
// RQ6 - Code six in either direction takes the user initial value from nonvolatile settings.
// RQ7 - With store-to-FIFO set the received CRC bytes go to the FIFO with the frame data.
// RQ8 - With store-to-FIFO clear the received CRC bytes are checked but not stored.
// RQ9 - Software sets store-to-FIFO whenever the received CRC is not byte aligned.
// RQ10 - With receive complement set the received CRC is compared with the inverted result.
// RQ11 - With receive check enabled a mismatching CRC sets the error flag.
// RQ12 - With receive check disabled the CRC is computed but the error flag is untouched.
// RQ13 - Each direction loads its selected initial value at the start of every frame.
module fccu_top
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire fccu_pkg::fccu_word_t user_init_crc16_in,
  input wire logic [7:0] user_init_crc8_in,
  input wire logic [4:0] user_init_crc5_in,
  input wire logic tx_frame_start_in,
  input wire logic tx_byte_valid_in,
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_frame_end_in,
  output logic tx_busy_out,
  output logic tx_valid_out,
  output logic [7:0] tx_byte_out,
  output logic tx_last_out,
  input wire logic rx_frame_start_in,
  input wire logic rx_byte_valid_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_byte_is_crc_in,
  input wire logic rx_frame_end_in,
  output logic fifo_wr_out,
  output logic [7:0] fifo_data_out,
  output logic crc_error_out
);
  import fccu_pkg::*;

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  function automatic fccu_word_t crc_mask(input fccu_poly_t poly);
    case (poly)
      `FCCU_POLY_CRC5: return `FCCU_MASK_CRC5;
      `FCCU_POLY_CRC8: return `FCCU_MASK_CRC8;
      default: return `FCCU_MASK_CRC16;
    endcase
  endfunction

  // Undefined codes load zero so that a bad setting still gives a known result.
  function automatic fccu_word_t init_value(input fccu_init_t sel, input fccu_poly_t poly,
                                            input fccu_word_t u16, input logic [7:0] u8,
                                            input logic [4:0] u5);
    logic is16;
    logic is8;
    is16 = (poly == `FCCU_POLY_CRC16) || (poly == `FCCU_POLY_RSVD);
    is8 = (poly == `FCCU_POLY_CRC8);
    case (sel)
      `FCCU_INIT_ZERO: return 16'h0000;
      `FCCU_INIT_CODE1: return is16 ? `FCCU_PRE1_CRC16 : `FCCU_PRE1_SHORT;
      `FCCU_INIT_CODE2: return is16 ? `FCCU_PRE2_CRC16 : (is8 ? `FCCU_PRE2_CRC8 : 16'h0000);
      `FCCU_INIT_CODE3: return is16 ? `FCCU_PRE3_CRC16 : (is8 ? `FCCU_PRE3_CRC8 : 16'h0000);
      `FCCU_INIT_USER: return is16 ? u16 : (is8 ? {8'h00, u8} : {11'h000, u5});
      `FCCU_INIT_ONES: return is16 ? `FCCU_PRE7_CRC16 : (is8 ? `FCCU_PRE7_CRC8 : `FCCU_PRE7_CRC5);
      default: return 16'h0000;
    endcase
  endfunction

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0] tx_setup_reg;
  logic [7:0] tx_setup_next;
  logic [7:0] rx_setup_reg;
  logic [7:0] rx_setup_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic err_reg;
  logic err_next;
  logic busy_reg;
  logic err_clear;

  fccu_poly_t tx_poly_sel;
  fccu_poly_t rx_poly_sel;
  fccu_init_t tx_init_sel;
  fccu_init_t rx_init_sel;
  logic tx_append_en;
  logic tx_compl;
  logic rx_check_en;
  logic rx_compl;
  logic rx_store;

  assign tx_poly_sel = tx_setup_reg[`FCCU_POLY_MSB:`FCCU_POLY_LSB];
  assign rx_poly_sel = rx_setup_reg[`FCCU_POLY_MSB:`FCCU_POLY_LSB];
  assign tx_init_sel = tx_setup_reg[`FCCU_INIT_MSB:`FCCU_INIT_LSB];
  assign rx_init_sel = rx_setup_reg[`FCCU_INIT_MSB:`FCCU_INIT_LSB];
  assign tx_append_en = tx_setup_reg[`FCCU_ENABLE_BIT];
  assign tx_compl = tx_setup_reg[`FCCU_COMPL_BIT];
  assign rx_check_en = rx_setup_reg[`FCCU_ENABLE_BIT];
  assign rx_compl = rx_setup_reg[`FCCU_COMPL_BIT];
  assign rx_store = rx_setup_reg[`FCCU_STORE_BIT];
  assign err_clear = reg_wr_in && (reg_addr_in == `FCCU_STATUS_ADDR)
                     && reg_wdata_in[`FCCU_STAT_ERR_BIT];

  // Writes store setup; reads answer one cycle later and read zero otherwise.
  always_comb
  begin
    tx_setup_next = tx_setup_reg;
    rx_setup_next = rx_setup_reg;
    rdata_next = 8'h00;
    if (reg_wr_in && (reg_addr_in == `FCCU_TX_SETUP_ADDR))
      tx_setup_next = reg_wdata_in & `FCCU_TX_SETUP_MASK;
    if (reg_wr_in && (reg_addr_in == `FCCU_RX_SETUP_ADDR))
      rx_setup_next = reg_wdata_in;
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        `FCCU_TX_SETUP_ADDR: rdata_next = tx_setup_reg;
        `FCCU_RX_SETUP_ADDR: rdata_next = rx_setup_reg;
        `FCCU_STATUS_ADDR: rdata_next = {6'h00, busy_reg, err_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Register stage.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      tx_setup_reg <= `FCCU_SETUP_RESET;
      rx_setup_reg <= `FCCU_SETUP_RESET;
      rdata_reg <= 8'h00;
    end
    else
    begin
      tx_setup_reg <= tx_setup_next;
      rx_setup_reg <= rx_setup_next;
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************************************
  // Transmit path
  // ****************************************************************
  fccu_crc_if tx_crc ();
  fccu_crc_if rx_crc ();
  fccu_crc_engine u_tx_engine (.clk_in(clk_in), .rst_in(rst_in), .crc_bus(tx_crc));
  fccu_crc_engine u_rx_engine (.clk_in(clk_in), .rst_in(rst_in), .crc_bus(rx_crc));

  fccu_tx_state_e tx_state_reg;
  fccu_tx_state_e tx_state_next;
  logic tx_valid_reg;
  logic tx_valid_next;
  logic [7:0] tx_byte_reg;
  logic [7:0] tx_byte_next;
  logic tx_last_reg;
  logic tx_last_next;
  fccu_word_t tx_crc_word;

  assign tx_crc_word = (tx_crc.crc ^ (tx_compl ? 16'hffff : 16'h0000)) & crc_mask(tx_poly_sel);
  assign tx_crc.init = tx_frame_start_in;
  assign tx_crc.init_value = init_value(tx_init_sel, tx_poly_sel, user_init_crc16_in,
                                        user_init_crc8_in, user_init_crc5_in); // [RQ4] [RQ6]
  assign tx_crc.poly = tx_poly_sel;
  assign tx_crc.feed = tx_byte_valid_in && (tx_state_reg == TX_PASS);
  assign tx_crc.data = tx_byte_in;

  // Data bytes pass through; at frame end the CRC bytes follow, low byte first.
  always_comb
  begin
    tx_state_next = tx_state_reg;
    tx_valid_next = 1'b0;
    tx_byte_next = tx_byte_reg;
    tx_last_next = 1'b0;
    case (tx_state_reg)
      TX_IDLE:
        if (tx_frame_start_in)
          tx_state_next = TX_PASS; // [RQ13]
      TX_PASS:
        if (tx_byte_valid_in)
        begin
          tx_valid_next = 1'b1;
          tx_byte_next = tx_byte_in;
        end
        else if (tx_frame_end_in)
        begin
          if (tx_append_en && (tx_poly_sel != `FCCU_POLY_RSVD))
            tx_state_next = TX_CRC_LO; // [RQ2] [RQ1]
          else
            tx_state_next = TX_IDLE;
        end
      TX_CRC_LO:
      begin
        tx_valid_next = 1'b1;
        tx_byte_next = tx_crc_word[7:0]; // [RQ3]
        if (tx_poly_sel == `FCCU_POLY_CRC16)
          tx_state_next = TX_CRC_HI;
        else
        begin
          tx_last_next = 1'b1;
          tx_state_next = TX_IDLE;
        end
      end
      TX_CRC_HI:
      begin
        tx_valid_next = 1'b1;
        tx_byte_next = tx_crc_word[15:8]; // [RQ3]
        tx_last_next = 1'b1;
        tx_state_next = TX_IDLE;
      end
      default: tx_state_next = TX_IDLE;
    endcase
  end

  // Register stage.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      tx_state_reg <= TX_IDLE;
      tx_valid_reg <= 1'b0;
      tx_byte_reg <= 8'h00;
      tx_last_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      tx_state_reg <= tx_state_next;
      tx_valid_reg <= tx_valid_next;
      tx_byte_reg <= tx_byte_next;
      tx_last_reg <= tx_last_next;
      busy_reg <= (tx_state_next == TX_CRC_LO) || (tx_state_next == TX_CRC_HI);
    end
  end

  // ****************************************************************
  // Receive path
  // ****************************************************************
  logic fifo_wr_reg;
  logic fifo_wr_next;
  logic [7:0] fifo_data_reg;
  logic [7:0] fifo_data_next;
  fccu_word_t rcvd_reg;
  fccu_word_t rcvd_next;
  logic rcvd_hi_reg;
  logic rcvd_hi_next;
  fccu_word_t rx_expect;
  logic rx_mismatch;

  assign rx_crc.init = rx_frame_start_in;
  assign rx_crc.init_value = init_value(rx_init_sel, rx_poly_sel, user_init_crc16_in,
                                        user_init_crc8_in, user_init_crc5_in); // [RQ5] [RQ6]
  assign rx_crc.poly = rx_poly_sel;
  assign rx_crc.feed = rx_byte_valid_in && !rx_byte_is_crc_in; // [RQ12]
  assign rx_crc.data = rx_byte_in;
  assign rx_expect = (rx_crc.crc ^ (rx_compl ? 16'hffff : 16'h0000)) & crc_mask(rx_poly_sel);
  assign rx_mismatch = rx_expect != (rcvd_reg & crc_mask(rx_poly_sel)); // [RQ10]

  // Data bytes always reach the FIFO; CRC bytes are captured and only stored on request.
  always_comb
  begin
    fifo_wr_next = 1'b0;
    fifo_data_next = fifo_data_reg;
    rcvd_next = rcvd_reg;
    rcvd_hi_next = rcvd_hi_reg;
    err_next = err_reg;
    if (rx_frame_start_in)
    begin
      rcvd_next = 16'h0000;
      rcvd_hi_next = 1'b0;
    end
    else if (rx_byte_valid_in)
    begin
      if (rx_byte_is_crc_in)
      begin
        if (rcvd_hi_reg)
          rcvd_next[15:8] = rx_byte_in;
        else
          rcvd_next[7:0] = rx_byte_in;
        rcvd_hi_next = 1'b1;
        fifo_wr_next = rx_store; // [RQ7] [RQ8]
      end
      else
        fifo_wr_next = 1'b1;
      fifo_data_next = rx_byte_in;
    end
    // A clear from software loses to a mismatch seen in the same cycle.
    if (err_clear)
      err_next = 1'b0;
    if (rx_frame_end_in && rx_check_en && (rx_poly_sel != `FCCU_POLY_RSVD) && rx_mismatch)
      err_next = 1'b1; // [RQ11] [RQ12]
  end

  // Register stage.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      fifo_wr_reg <= 1'b0;
      fifo_data_reg <= 8'h00;
      rcvd_reg <= 16'h0000;
      rcvd_hi_reg <= 1'b0;
      err_reg <= 1'b0;
    end
    else
    begin
      fifo_wr_reg <= fifo_wr_next;
      fifo_data_reg <= fifo_data_next;
      rcvd_reg <= rcvd_next;
      rcvd_hi_reg <= rcvd_hi_next;
      err_reg <= err_next;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign tx_busy_out = busy_reg;
  assign tx_valid_out = tx_valid_reg;
  assign tx_byte_out = tx_byte_reg;
  assign tx_last_out = tx_last_reg;
  assign fifo_wr_out = fifo_wr_reg;
  assign fifo_data_out = fifo_data_reg;
  assign crc_error_out = err_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  a_crc5_one_byte: assert property (tx_state_reg == TX_CRC_LO // [RQ1]
    && tx_poly_sel == `FCCU_POLY_CRC5 |=> tx_last_out && tx_valid_out && tx_state_reg == TX_IDLE)
    else $error("CRC5 append did not end after one byte");
  a_append_follows_end: assert property ((tx_state_reg == TX_PASS) && !tx_byte_valid_in // [RQ2]
    && tx_frame_end_in && tx_append_en && (tx_poly_sel != `FCCU_POLY_RSVD)
    |=> (tx_state_reg == TX_CRC_LO) && tx_busy_out ##1 tx_valid_out)
    else $error("CRC was not appended after frame end");
  a_no_append_off: assert property ((tx_state_reg == TX_PASS) && !tx_byte_valid_in // [RQ2]
    && tx_frame_end_in && !tx_append_en |=> (tx_state_reg == TX_IDLE) ##1 !tx_valid_out)
    else $error("CRC appended while append disabled");
  a_tx_crc_value: assert property ((tx_state_reg == TX_CRC_LO) // [RQ3]
    && (tx_poly_sel == `FCCU_POLY_CRC16) |=> (tx_byte_out == $past(tx_crc_word[7:0]))
    ##1 (tx_byte_out == $past(tx_crc_word[15:8], 2)))
    else $error("Appended CRC bytes wrong");
  a_tx_init_load: assert property (tx_frame_start_in // [RQ4] [RQ13]
    |=> tx_crc.crc == $past(tx_crc.init_value))
    else $error("Transmit initial value not loaded");
  a_rx_init_load: assert property (rx_frame_start_in // [RQ5] [RQ6]
    && (rx_init_sel == `FCCU_INIT_USER) && (rx_poly_sel == `FCCU_POLY_CRC8)
    |=> rx_crc.crc == {8'h00, $past(user_init_crc8_in)})
    else $error("Receive user initial value not loaded");
  a_crc_store_on: assert property (rx_byte_valid_in && !rx_frame_start_in // [RQ7]
    && rx_byte_is_crc_in && rx_store |=> fifo_wr_out && (fifo_data_out == $past(rx_byte_in)))
    else $error("Received CRC byte not stored");
  a_crc_store_off: assert property (rx_byte_valid_in && !rx_frame_start_in // [RQ8]
    && rx_byte_is_crc_in && !rx_store |=> !fifo_wr_out)
    else $error("Received CRC byte stored while storing disabled");
  a_err_on_mismatch: assert property (rx_frame_end_in && rx_check_en // [RQ10] [RQ11]
    && (rx_poly_sel != `FCCU_POLY_RSVD) && rx_mismatch |=> crc_error_out)
    else $error("CRC mismatch did not raise error");
  a_err_untouched: assert property (!rx_check_en && !err_clear // [RQ12]
    |=> $stable(crc_error_out))
    else $error("Error flag changed while checking disabled");

  c_tx_crc16: cover property ((tx_state_reg == TX_CRC_HI) ##1 tx_last_out);
  c_rx_error: cover property (rx_frame_end_in ##1 $rose(crc_error_out));
  c_rx_store: cover property (rx_byte_is_crc_in && rx_byte_valid_in && rx_store ##1 fifo_wr_out);
endmodule

// ---- fccu_far_model.sv ----
// Purpose: Framing logic and FIFO on the far side of the CRC unit.
// Assumes: Driven from the bench through its tasks; one clock.
// Notes: Bytes seen on the transmit and FIFO outputs are queued for checking.
`timescale 1ns/1ns
module fccu_far_model
(
  input wire logic clk_in,
  output logic tx_start_out,
  output logic tx_valid_out,
  output logic [7:0] tx_byte_out,
  output logic tx_end_out,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_byte_in,
  output logic rx_start_out,
  output logic rx_valid_out,
  output logic [7:0] rx_byte_out,
  output logic rx_is_crc_out,
  output logic rx_end_out,
  input wire logic fifo_wr_in,
  input wire logic [7:0] fifo_data_in
);
  logic [7:0] txq[$], fq[$];

  // ************************************************************
  // Frame drivers
  // ************************************************************
  // All strobes idle low from time zero.
  initial
  begin
    {tx_start_out, tx_valid_out, tx_end_out, rx_start_out, rx_valid_out} = '0;
    {rx_is_crc_out, rx_end_out, tx_byte_out, rx_byte_out} = '0;
  end

  // End comes in a cycle of its own; idle data is inverted so stale bytes never match.
  task automatic send_tx(input logic [7:0] d[$]);
    @(posedge clk_in) tx_start_out <= 1'b1;
    foreach (d[i])
    begin
      @(posedge clk_in) tx_start_out <= 1'b0;
      tx_valid_out <= 1'b1;
      tx_byte_out <= d[i];
    end
    @(posedge clk_in) tx_valid_out <= 1'b0;
    tx_byte_out <= ~tx_byte_out;
    tx_end_out <= 1'b1;
    @(posedge clk_in) tx_end_out <= 1'b0;
  endtask

  // Data bytes, then CRC bytes low first, one idle cycle, then end.
  task automatic send_rx(input logic [7:0] d[$], input logic [7:0] c[$]);
    @(posedge clk_in) rx_start_out <= 1'b1;
    foreach (d[i])
    begin
      @(posedge clk_in) rx_start_out <= 1'b0;
      rx_valid_out <= 1'b1;
      rx_byte_out <= d[i];
    end
    foreach (c[i])
    begin
      @(posedge clk_in) rx_is_crc_out <= 1'b1;
      rx_byte_out <= c[i];
    end
    @(posedge clk_in) {rx_valid_out, rx_is_crc_out} <= 2'b00;
    rx_byte_out <= ~rx_byte_out;
    @(posedge clk_in) rx_end_out <= 1'b1;
    @(posedge clk_in) rx_end_out <= 1'b0;
  endtask

  // Capture of every byte the unit hands on.
  always @(posedge clk_in)
  begin
    if (tx_valid_in === 1'b1) txq.push_back(tx_byte_in);
    if (fifo_wr_in === 1'b1) fq.push_back(fifo_data_in);
  end
endmodule

// ---- tb_frame_crc_config_unit.sv ----
// Purpose: Self-checking bench of the CRC unit with random frames and setups.
// Assumes: Setup registers at 0x2c and 0x2d, status at 0x3f with write-one-to-clear error.
// Notes: Expected CRCs come from a bit-serial model in the bench.
`timescale 1ns/1ns
`include "fccu_defines.svh"
module tb_frame_crc_config_unit;
  import fccu_pkg::*;
  logic clk_in, rst_in, reg_wr_in, reg_rd_in, tx_busy_out, tx_valid_out, tx_last_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, tx_byte_out, fifo_data_out;
  logic tx_start, tx_valid, tx_end, rx_start, rx_valid, rx_is_crc, rx_end, fifo_wr_out;
  logic crc_error_out, err_exp;
  logic [7:0] tx_byte, rx_byte, u8, rd_v;
  logic [4:0] u5;
  fccu_word_t u16;
  logic [7:0] d[$], c[$], e[$];
  int errors = 0, checks_done = 0;

  fccu_top dut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .user_init_crc16_in(u16), .user_init_crc8_in(u8),
    .user_init_crc5_in(u5), .tx_frame_start_in(tx_start), .tx_byte_valid_in(tx_valid),
    .tx_byte_in(tx_byte), .tx_frame_end_in(tx_end), .tx_busy_out(tx_busy_out),
    .tx_valid_out(tx_valid_out), .tx_byte_out(tx_byte_out), .tx_last_out(tx_last_out),
    .rx_frame_start_in(rx_start), .rx_byte_valid_in(rx_valid), .rx_byte_in(rx_byte),
    .rx_byte_is_crc_in(rx_is_crc), .rx_frame_end_in(rx_end), .fifo_wr_out(fifo_wr_out),
    .fifo_data_out(fifo_data_out), .crc_error_out(crc_error_out));
  fccu_far_model far (.clk_in(clk_in), .tx_start_out(tx_start), .tx_valid_out(tx_valid),
    .tx_byte_out(tx_byte), .tx_end_out(tx_end), .tx_valid_in(tx_valid_out),
    .tx_byte_in(tx_byte_out), .rx_start_out(rx_start), .rx_valid_out(rx_valid),
    .rx_byte_out(rx_byte), .rx_is_crc_out(rx_is_crc), .rx_end_out(rx_end),
    .fifo_wr_in(fifo_wr_out), .fifo_data_in(fifo_data_out));

  // ************************************************************
  // Clock, expectation model and bus tasks
  // ************************************************************
  // A 40 ns clock.
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  function automatic fccu_word_t mask_of(input fccu_poly_t p);
    return p[1] ? 16'hffff : (p == 2'h1 ? 16'h00ff : 16'h001f);
  endfunction

  // Code three is treated as CRC16; undefined codes load zero.
  function automatic fccu_word_t pre_of(input fccu_poly_t p, input fccu_init_t k);
    case (k)
      3'h1: return p[1] ? 16'h6363 : 16'h0012;
      3'h2: return p[1] ? 16'ha671 : (p == 2'h1 ? 16'h00bf : 16'h0000);
      3'h3: return p[1] ? 16'hfffe : (p == 2'h1 ? 16'h00fd : 16'h0000);
      3'h6: return p[1] ? u16 : (p == 2'h1 ? {8'h00, u8} : {11'h000, u5});
      3'h7: return mask_of(p);
      default: return 16'h0000;
    endcase
  endfunction

  // Bit-serial reflected CRC, least significant bit first.
  function automatic fccu_word_t crc_of(input fccu_poly_t p, input fccu_init_t k,
                                        input logic [7:0] b[$]);
    fccu_word_t r, g;
    r = pre_of(p, k);
    g = p[1] ? `FCCU_REV_POLY_CRC16 : (p == 2'h1 ? `FCCU_REV_POLY_CRC8 : `FCCU_REV_POLY_CRC5);
    foreach (b[i])
    begin
      r = r ^ {8'h00, b[i]};
      repeat (8) r = r[0] ? ((r >> 1) ^ g) : (r >> 1);
    end
    return r & mask_of(p);
  endfunction

  task automatic chk(input string what, input fccu_word_t exp, input fccu_word_t got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in) {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, v, 1'b1};
    @(posedge clk_in) reg_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_in) {reg_addr_in, reg_rd_in} <= {a, 1'b1};
    @(posedge clk_in) reg_rd_in <= 1'b0;
    #1 rd_v = reg_rdata_out;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial
  begin : main
    fccu_poly_t p;
    fccu_init_t k;
    logic cm, en, st, bad;
    fccu_word_t x;
    {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in, u16, u8, u5, err_exp} = '0;
    void'($urandom(32'h733b));
    rst_in = 1'b1;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    // Reset values, the masked top bit and an unmapped address.
    rd(8'h2c); chk("tx setup reset", 16'h0000, rd_v);
    rd(8'h2d); chk("rx setup reset", 16'h0000, rd_v);
    wr(8'h2c, 8'hff); rd(8'h2c); chk("tx setup", 16'h007f, rd_v);
    wr(8'h2d, 8'ha5); rd(8'h2d); chk("rx setup", 16'h00a5, rd_v);
    wr(8'h10, 8'hff); rd(8'h10); chk("unmapped", 16'h0000, rd_v);
    $display("register test done");
    // Transmit: every polynomial and initial code over random frames.
    for (int t = 0; t < 64; t++)
    begin
      {p, k, cm, en} = {t[1:0], t[4:2], 2'($urandom)};
      {u16, u8, u5} <= 29'($urandom);
      wr(8'h2c, {1'($urandom), k, p, cm, en});
      d.delete(); far.txq.delete();
      repeat (1 + $urandom % 4) d.push_back(8'($urandom));
      e = d;
      @(posedge clk_in);
      x = crc_of(p, k, d) ^ (cm ? mask_of(p) : 16'h0000);
      if (en && p != 2'h3) e.push_back(x[7:0]);
      if (en && p == 2'h2) e.push_back(x[15:8]);
      far.send_tx(d);
      @(posedge clk_in) #1 chk("tx last", en && p < 2'h2, tx_last_out);
      @(posedge clk_in) #1 chk("tx last", en && p == 2'h2, tx_last_out);
      repeat (3) @(posedge clk_in);
      chk("tx busy", 16'h0000, tx_busy_out);
      chk("tx count", e.size(), far.txq.size());
      foreach (e[i]) if (i < far.txq.size()) chk("tx byte", e[i], far.txq[i]);
    end
    $display("transmit test done");
    // Receive: good and bad CRCs, check and store settings, sticky error.
    for (int t = 0; t < 128; t++)
    begin
      {p, k, cm, en, st, bad} = {t[1:0], t[4:2], 4'($urandom)};
      {u16, u8, u5} <= 29'($urandom);
      // Frames here are byte aligned, so the store bit may take either value.
      wr(8'h2d, {st, k, p, cm, en});
      if ($urandom % 2)
      begin
        wr(8'h3f, 8'h01);
        err_exp = 1'b0;
      end
      d.delete(); c.delete(); far.fq.delete();
      repeat (1 + $urandom % 4) d.push_back(8'($urandom));
      @(posedge clk_in);
      x = (crc_of(p, k, d) ^ (cm ? mask_of(p) : 16'h0000)) ^ {15'h0000, bad};
      c.push_back(x[7:0]);
      if (p[1]) c.push_back(x[15:8]);
      e = d;
      if (st) e = {d, c};
      if (en && p != 2'h3 && bad) err_exp = 1'b1;
      far.send_rx(d, c);
      repeat (2) @(posedge clk_in);
      #1 chk("crc error", err_exp, crc_error_out);
      rd(8'h3f); chk("status", {7'h00, err_exp}, rd_v);
      chk("fifo count", e.size(), far.fq.size());
      foreach (e[i]) if (i < far.fq.size()) chk("fifo byte", e[i], far.fq[i]);
    end
    $display("receive test done");
    results();
  end
endmodule
